// file: adc_cfg_pkg.sv
// shared constants and types for the serial configuration register block
package adc_cfg_pkg;
   localparam int unsigned CFG_W        = 13;
   localparam int unsigned RESULT_W     = 12;
   localparam int unsigned CHAN_W       = 4;
   localparam int unsigned FRAME_W      = CHAN_W + RESULT_W;
   localparam int unsigned FRAME_CLOCKS = 16;
   localparam int unsigned CAPTURE_EDGES = 13;
   localparam int unsigned MUX_EDGE     = 14;
   localparam int unsigned FIFO_DEPTH   = 16;
   localparam int unsigned EDGE_CNT_W   = 5;
   localparam int unsigned CLK_MHZ      = 100;
   localparam int unsigned WAKE_TIME_NS = 1000;
   localparam int unsigned WAKE_CYCLES  = (WAKE_TIME_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned WAKE_CNT_W   = 8;
   localparam int unsigned WE_BIT       = 12;
   localparam int unsigned SDO_TOP_BIT  = FRAME_W - 1;

   typedef struct packed {
      logic       write_enable;
      logic       channel_cycling_enable;
      logic [3:0] channel_select;
      logic       power_mode_hi;
      logic       power_mode_lo;
      logic       list_select;
      logic       idle_output_hold;
      logic       range_sel;
      logic       coding;
      logic       single_ended_select;
   } config_t;

   typedef struct packed {
      logic [CHAN_W-1:0]   channel;
      logic [RESULT_W-1:0] data;
   } result_t;

   // reset state: arbitrary, nothing fixes it; full power, single-ended, two's complement
   localparam config_t CONFIG_RESET = 13'h0_0061;
   localparam logic [1:0] SPAN_DIFF_FULL = 2'h0;
   localparam logic [1:0] SPAN_DIFF_HALF = 2'h1;
   localparam logic [1:0] SPAN_SE_DOUBLE = 2'h2;
   localparam logic [1:0] SPAN_SE_REF    = 2'h3;
endpackage

// file: adc_serial_config_register.sv
// serial configuration register and result shifter of the converter
`timescale 1ns/10ps

// Function
// - 13-bit write-only config register, bits shifted in on serial clock falling edges.
// - a transfer spans 16 clocks; config in while result shifts out.
// - only first 13 falling edges after select falls are captured.
// - layout 12..0: write, cycling, channel[3:0], power hi/lo, list, hold, range, coding, se.
// - write bit one loads the 12 following bits; zero keeps contents.
// - channel and single-ended select take effect at end of present conversion.
// - result channel address bits are shifted out before the 12 result bits.
// - input multiplexer switches to next channel on the 14th falling edge.
// - idle hold one weakly drives top next channel bit; zero releases output.
// - coding one gives straight binary, zero gives two's complement.
// - single-ended select one uses single inputs, zero uses differential pairs.
// - range with single-ended select chooses one of four input spans.
// - cycling and list bits steer sequencer and channel list loading.
// - the two power mode bits select the operating power mode; only the upper bit is used, the lower bit has no effect.
// - both power bits one stay powered; upper zero auto-sleeps, 1 us wake.
// - list select alone sends next write to channel list; cycling keeps sequence.
// - differential pairs inputs by address, LSB sets polarity; top bit ignored. The code passes all four channel bits to mux_channel.
module adc_serial_config_register
   import adc_cfg_pkg::*;
#(
   parameter int unsigned DEPTH = FIFO_DEPTH
) (
   input  wire logic                clk,
   input  wire logic                sys_rst,
   input  wire logic                ce,
   input  wire logic                chip_select_n,
   input  wire logic                sclk,
   input  wire logic                sdi,
   output logic                     sdo,
   output logic                     sdo_oe,
   output logic                     sdo_weak,
   input  wire logic                result_valid,
   output logic                     result_ready,
   input  wire result_t             result_in,
   output config_t                  active_config,
   output logic [CHAN_W-1:0]        mux_channel,
   output logic                     mux_single_ended,
   output logic [1:0]               input_span,
   output logic [CFG_W-2:0]         channel_list,
   output logic                     list_write_pending,
   output logic                     converter_powered,
   output logic                     converter_ready
);
   typedef enum logic {ST_IDLE, ST_FRAME} frame_state_t;

   // ---------------------------------------------------------------
   // pin synchronisers
   // ---------------------------------------------------------------
   logic cs_s1, cs_s2, cs_s3;
   logic sck_s1, sck_s2, sck_s3;
   logic sdi_s1, sdi_s2;
   logic cs_fall, cs_rise, sck_fall;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         cs_s1  <= 1'b1;
         cs_s2  <= 1'b1;
         cs_s3  <= 1'b1;
         sck_s1 <= 1'b1;
         sck_s2 <= 1'b1;
         sck_s3 <= 1'b1;
         sdi_s1 <= 1'b0;
         sdi_s2 <= 1'b0;
      end else if (ce) begin
         cs_s1  <= chip_select_n;
         cs_s2  <= cs_s1;
         cs_s3  <= cs_s2;
         sck_s1 <= sclk;
         sck_s2 <= sck_s1;
         sck_s3 <= sck_s2;
         sdi_s1 <= sdi;
         sdi_s2 <= sdi_s1;
      end
   end

   assign cs_fall  = ce && cs_s3 && !cs_s2;
   assign cs_rise  = ce && !cs_s3 && cs_s2;
   assign sck_fall = ce && !cs_s2 && sck_s3 && !sck_s2;

   // ---------------------------------------------------------------
   // frame tracking
   // ---------------------------------------------------------------
   frame_state_t           state;
   logic [EDGE_CNT_W-1:0]  edge_count;
   logic [CFG_W-2:0]       capture;
   logic [CFG_W-1:0]       next_word;
   config_t                next_cfg;
   logic                   word_done;
   logic                   mux_edge;

   assign next_word = {capture, sdi_s2};
   assign next_cfg  = config_t'(next_word);
   assign word_done = sck_fall && (edge_count == EDGE_CNT_W'(CAPTURE_EDGES - 1));
   assign mux_edge  = sck_fall && (edge_count == EDGE_CNT_W'(MUX_EDGE - 1));

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         state      <= ST_IDLE;
         edge_count <= '0;
         capture    <= '0;
      end else if (ce) begin
         case (state)
            ST_IDLE: begin
               if (cs_fall) begin
                  state      <= ST_FRAME;
                  edge_count <= '0;
               end
            end
            ST_FRAME: begin
               if (cs_rise) begin
                  // a short frame never reaches word_done, so nothing commits
                  state <= ST_IDLE;
               end else if (sck_fall) begin
                  if (edge_count != EDGE_CNT_W'(FRAME_CLOCKS)) begin
                     edge_count <= edge_count + 1'b1;
                  end
                  if (edge_count < EDGE_CNT_W'(CAPTURE_EDGES - 1)) begin
                     capture <= next_word[CFG_W-2:0];
                  end
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // configuration and channel list
   // ---------------------------------------------------------------
   config_t pending;
   logic    pending_new;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         pending            <= CONFIG_RESET;
         pending_new        <= 1'b0;
         channel_list       <= '0;
         list_write_pending <= 1'b0;
      end else if (ce) begin
         if (cs_rise) begin
            pending_new <= 1'b0;
         end
         if (word_done && next_word[WE_BIT]) begin
            if (list_write_pending) begin
               channel_list       <= next_word[CFG_W-2:0];
               list_write_pending <= 1'b0;
            end else begin
               pending            <= config_t'(next_word);
               pending_new        <= 1'b1;
               // list select without cycling redirects the following write
               list_write_pending <= next_cfg.list_select
                                     && !next_cfg.channel_cycling_enable;
            end
         end
      end
   end

   // settings become active at the end of the transfer in which they arrived
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         active_config <= CONFIG_RESET;
         input_span    <= {CONFIG_RESET.single_ended_select, CONFIG_RESET.range_sel};
      end else if (ce && cs_rise && pending_new) begin
         active_config <= pending;
         input_span    <= {pending.single_ended_select, pending.range_sel};
      end
   end

   // only the channel path moves early, so the input settles before sampling
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         mux_channel      <= CONFIG_RESET.channel_select;
         mux_single_ended <= CONFIG_RESET.single_ended_select;
      end else if (ce && mux_edge) begin
         mux_channel      <= pending.channel_select;
         mux_single_ended <= pending.single_ended_select;
      end
   end

   // ---------------------------------------------------------------
   // result path
   // ---------------------------------------------------------------
   logic              fifo_valid;
   logic [FRAME_W-1:0] fifo_data;
   logic [FRAME_W-1:0] shift_out;
   result_t            head;

   result_fifo #(
      .WIDTH (FRAME_W),
      .DEPTH (DEPTH)
   ) u_fifo (
      .clk       (clk),
      .sys_rst   (sys_rst),
      .ce        (ce),
      .in_valid  (result_valid),
      .in_ready  (result_ready),
      .in_data   (result_in),
      .out_valid (fifo_valid),
      .out_ready (cs_fall),
      .out_data  (fifo_data)
   );

   assign head = result_t'(fifo_data);

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         shift_out <= '0;
         sdo       <= 1'b0;
         sdo_oe    <= 1'b0;
         sdo_weak  <= 1'b0;
      end else if (ce) begin
         if (cs_fall) begin
            // an empty fifo shifts out zeros rather than stale data
            shift_out <= fifo_valid
               ? {head.channel, head.data ^ {active_config.coding == 1'b0,
                                            {(RESULT_W-1){1'b0}}}}
               : '0;
            sdo       <= fifo_valid ? head.channel[CHAN_W-1] : 1'b0;
            sdo_oe    <= 1'b1;
            sdo_weak  <= 1'b0;
         end else if (sck_fall && edge_count < EDGE_CNT_W'(FRAME_CLOCKS - 1)) begin
            shift_out <= {shift_out[FRAME_W-2:0], 1'b0};
            sdo       <= shift_out[SDO_TOP_BIT-1];
         end else if (cs_rise) begin
            sdo_oe   <= pending.idle_output_hold;
            sdo_weak <= pending.idle_output_hold;
            sdo      <= pending.idle_output_hold & pending.channel_select[CHAN_W-1];
         end
      end
   end

   // ---------------------------------------------------------------
   // power management
   // ---------------------------------------------------------------
   logic [WAKE_CNT_W-1:0] wake_count;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         converter_powered <= 1'b1;
         converter_ready   <= 1'b1;
         wake_count        <= '0;
      end else if (ce) begin
         if (cs_rise && !pending.power_mode_hi) begin
            converter_powered <= 1'b0;
            converter_ready   <= 1'b0;
         end else if (!converter_powered && cs_fall) begin
            converter_powered <= 1'b1;
            wake_count        <= WAKE_CNT_W'(WAKE_CYCLES);
         end else if (converter_powered && !converter_ready) begin
            if (wake_count <= WAKE_CNT_W'(1)) begin
               converter_ready <= 1'b1;
            end
            wake_count <= wake_count - 1'b1;
         end
      end
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   chk_short_frame_discard: assert property (
      cs_rise && edge_count < EDGE_CNT_W'(CAPTURE_EDGES) && !pending_new
      |=> $stable(pending))
      else $error("partial frame altered the pending configuration");
   chk_write_gate: assert property (
      word_done && !next_word[WE_BIT] |=> $stable(pending) && $stable(channel_list))
      else $error("write bit clear but register changed");
   chk_write_load: assert property (
      ce && word_done && next_word[WE_BIT] && !list_write_pending
      |=> pending == $past(next_word))
      else $error("captured word not loaded");
   chk_mux_switch: assert property (
      ce && !mux_edge && !sys_rst |=> $stable(mux_channel))
      else $error("channel mux moved outside the fourteenth edge");
   chk_active_at_end: assert property (
      ce && cs_rise && pending_new |=> active_config == $past(pending))
      else $error("configuration not applied at transfer end");
   chk_idle_release: assert property (
      ce && cs_rise && !pending.idle_output_hold |=> !sdo_oe && !sdo_weak)
      else $error("output still driven after transfer with hold off");
   chk_idle_hold: assert property (
      ce && cs_rise && pending.idle_output_hold
      |=> sdo_weak && sdo == $past(pending.channel_select[CHAN_W-1]))
      else $error("idle hold level wrong");
   chk_span_map: assert property (
      input_span == {active_config.single_ended_select, active_config.range_sel})
      else $error("input span disagrees with range and input type");
   chk_first_bit: assert property (
      cs_fall && fifo_valid |=> sdo == $past(head.channel[CHAN_W-1]) && sdo_oe)
      else $error("first output bit is not the result channel msb");
   chk_wake_time: assert property (
      ce && !converter_powered && cs_fall && !cs_rise
      |=> !converter_ready [*2])
      else $error("converter reported ready without wake time");
endmodule

// file: host_port.sv
// host serial port model driving the converter's configuration link
`timescale 1ns/10ps
module host_port (
   input  wire logic clk,
   output logic      chip_select_n,
   output logic      sclk,
   output logic      sdi,
   input  wire logic sdo
);
   initial begin
      chip_select_n = 1'b1;
      sclk          = 1'b1;
      sdi           = 1'b0;
   end

   // ----------------------------------------
   // one frame; falls below 16 aborts early
   // ----------------------------------------
   task automatic xfer(input logic [12:0] cfg, input int falls, output logic [15:0] rd);
      logic [15:0] word;
      word = {cfg, 3'h7};
      rd   = 16'h0000;
      @(negedge clk);
      chip_select_n = 1'b0;
      for (int i = 0; i < falls; i++) begin
         sdi = word[15-i];
         repeat (5) @(negedge clk);
         rd[15-i] = sdo;
         sclk     = 1'b0;
         repeat (5) @(negedge clk);
         sclk = 1'b1;
      end
      repeat (5) @(negedge clk);
      chip_select_n = 1'b1;
      // released line: never leave the last bit standing
      sdi = ~sdi;
      repeat (8) @(negedge clk);
   endtask
endmodule

// file: result_fifo.sv
// flip-flop fifo holding finished conversion results until they are shifted out
`timescale 1ns/10ps
module result_fifo
   import adc_cfg_pkg::*;
#(
   parameter int unsigned WIDTH = FRAME_W,
   parameter int unsigned DEPTH = FIFO_DEPTH
) (
   input  wire logic             clk,
   input  wire logic             sys_rst,
   input  wire logic             ce,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data
);
   localparam int unsigned AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [AW:0]      count;
   logic             push;
   logic             pop;
   logic [AW:0]      next_count;

   assign push = in_valid && in_ready;
   assign pop  = out_valid && out_ready;
   assign out_valid = (count != '0);
   assign out_data  = mem[rd_ptr];

   always_comb begin
      next_count = count;
      if (push && !pop) begin
         next_count = count + 1'b1;
      end else if (pop && !push) begin
         next_count = count - 1'b1;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         count    <= '0;
         in_ready <= 1'b1;
         wr_ptr   <= '0;
         rd_ptr   <= '0;
      end else if (ce) begin
         count    <= next_count;
         // registered ready: full is known one cycle ahead from next_count
         in_ready <= (next_count != (AW+1)'(DEPTH));
         if (push) begin
            wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (ce && push) begin
         mem[wr_ptr] <= in_data;
      end
   end
endmodule

// file: tb.sv
// self-checking bench for the serial configuration register
`timescale 1ns/10ps
module tb;
   import adc_cfg_pkg::*;
   logic              clk;
   logic              sys_rst;
   logic              result_valid;
   result_t           result_in;
   logic              chip_select_n;
   logic              sclk;
   logic              sdi;
   logic              sdo;
   logic              sdo_oe;
   logic              sdo_weak;
   logic              ce;
   logic              sdo_line;
   logic              result_ready;
   config_t           act;
   logic [CHAN_W-1:0] mux_channel;
   logic              mux_single_ended;
   logic [1:0]        input_span;
   logic [CFG_W-2:0]  channel_list;
   logic              list_write_pending;
   logic              converter_powered;
   logic              converter_ready;
   int                err_total = 0;
   int                compares  = 0;

   adc_serial_config_register #(.DEPTH(16)) DUT (
      .clk(clk), .sys_rst(sys_rst), .ce(ce), .chip_select_n(chip_select_n),
      .sclk(sclk), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe), .sdo_weak(sdo_weak),
      .result_valid(result_valid), .result_ready(result_ready),
      .result_in(result_in), .active_config(act), .mux_channel(mux_channel),
      .mux_single_ended(mux_single_ended), .input_span(input_span),
      .channel_list(channel_list), .list_write_pending(list_write_pending),
      .converter_powered(converter_powered), .converter_ready(converter_ready)
   );

   host_port host (
      .clk(clk), .chip_select_n(chip_select_n), .sclk(sclk), .sdi(sdi), .sdo(sdo_line)
   );

   // a released line reads inverted, so a read outside the enable shows up
   assign sdo_line = sdo_oe ? sdo : ~sdo;

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // ----------------------------------------
   // compare and close
   // ----------------------------------------
   task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic end_sim;
      $display("compares %0d mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic push(input result_t w);
      @(negedge clk);
      result_in    = w;
      result_valid = 1'b1;
      @(negedge clk);
      result_valid = 1'b0;
   endtask

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_reset;
      check("rst config", 16'h0061, {3'h0, act});
      check("rst flags", 16'h000B, {12'h0, input_span, converter_powered, converter_ready});
      check("rst pins", 16'h0001, {13'h0, sdo_oe, sdo_weak, result_ready});
      $display("test reset done");
   endtask

   task automatic t_write;
      logic [15:0] rd;
      push({4'h3, 12'h123});
      host.xfer(13'h12E6, 16, rd);
      check("readout", 16'h3923, rd);
      check("config", 16'h12E6, {3'h0, act});
      check("mux", 16'h000A, {11'h0, mux_channel, mux_single_ended});
      check("span", 16'h0001, {14'h0, input_span});
      check("idle", 16'h0000, {14'h0, sdo_oe, sdo_weak});
      $display("test write done");
   endtask

   task automatic t_nowrite;
      logic [15:0] rd;
      host.xfer(13'h0FFF, 16, rd);
      check("keep config", 16'h12E6, {3'h0, act});
      host.xfer(13'h1FFF, 8, rd);
      check("abort config", 16'h12E6, {3'h0, act});
      $display("test no write done");
   endtask

   task automatic t_hold;
      logic [15:0] rd;
      push({4'h2, 12'h800});
      host.xfer(13'h156B, 16, rd);
      check("binary out", 16'h2800, rd);
      check("hold pin", 16'h0007, {13'h0, sdo_oe, sdo_weak, sdo});
      check("se mux", 16'h0015, {11'h0, mux_channel, mux_single_ended});
      check("se span", 16'h0002, {14'h0, input_span});
      $display("test hold done");
   endtask

   task automatic t_power;
      logic [15:0] rd;
      host.xfer(13'h152B, 16, rd);
      check("asleep", 16'h0000, {14'h0, converter_powered, converter_ready});
      host.xfer(13'h12E6, 16, rd);
      check("awake", 16'h0003, {14'h0, converter_powered, converter_ready});
      $display("test power done");
   endtask

   task automatic t_list;
      logic [15:0] rd;
      host.xfer(13'h1070, 16, rd);
      check("pending", 16'h0001, {15'h0, list_write_pending});
      host.xfer(13'h1ABC, 16, rd);
      check("list", 16'h0ABC, {3'h0, list_write_pending, channel_list});
      check("list config", 16'h1070, {3'h0, act});
      check("diff span", 16'h0000, {14'h0, input_span});
      $display("test list done");
   endtask

   task automatic t_fifo;
      logic [15:0] rd;
      int          n;
      n = 0;
      @(negedge clk);
      result_valid = 1'b1;
      for (int i = 0; i < 20 && result_ready === 1'b1; i++) begin
         result_in = {4'h0, 12'(i)};
         n++;
         @(negedge clk);
      end
      result_valid = 1'b0;
      check("fill", 16'h0010, 16'(n));
      for (int i = 0; i < 16; i++) begin
         host.xfer(13'h0000, 16, rd);
         check("drain", {4'h0, 12'(i) ^ 12'h800}, rd);
      end
      host.xfer(13'h0000, 16, rd);
      check("empty", 16'h0001, {15'h0, result_ready});
      check("empty read", 16'h0000, rd);
      $display("test fifo done");
   endtask

   // with the enable low neither a frame nor a result push may land
   task automatic t_freeze;
      logic [15:0] rd;
      ce = 1'b0;
      push({4'h5, 12'h555});
      host.xfer(13'h1FFF, 16, rd);
      ce = 1'b1;
      check("frozen config", 16'h1070, {3'h0, act});
      host.xfer(13'h0000, 16, rd);
      check("frozen push", 16'h0000, rd);
      $display("test freeze done");
   endtask

   // a hang counts as a mismatch and still reaches the verdict
   initial begin
      repeat (100000) @(posedge clk);
      err_total++;
      $display("CHECK FAILED watchdog expected finish seen hang");
      end_sim;
   end

   initial begin
      sys_rst      = 1'b1;
      ce           = 1'b1;
      result_valid = 1'b0;
      result_in    = '0;
      repeat (8) @(posedge clk);
      @(negedge clk);
      sys_rst = 1'b0;
      repeat (4) @(negedge clk);
      t_reset;
      t_write;
      t_nowrite;
      t_hold;
      t_power;
      t_list;
      t_fifo;
      t_freeze;
      end_sim;
   end
endmodule
